// file: design/scd_consts.vh
// Constants for the command decoder: command codes, bit positions, timing.
// Assumes inclusion by design and bench files; definitions only.
`ifndef SCD_CONSTS_VH
`define SCD_CONSTS_VH
// Command codes {ras_n, cas_n, we_n}, chip select low
`define SCD_CODE_ACT 3'h3
`define SCD_CODE_PRE 3'h2
`define SCD_CODE_WR 3'h4
`define SCD_CODE_RD 3'h5
`define SCD_CODE_MRW 3'h0
`define SCD_CODE_NOP 3'h7
`define SCD_CODE_REF 3'h1
`define SCD_CODE_ZQ 3'h6
// Decoded command reported on cmd_out
`define SCD_CMD_NONE 4'h0
`define SCD_CMD_ACT 4'h1
`define SCD_CMD_PRE 4'h2
`define SCD_CMD_PREA 4'h3
`define SCD_CMD_WR 4'h4
`define SCD_CMD_RD 4'h5
`define SCD_CMD_MRW 4'h6
`define SCD_CMD_REF 4'h7
`define SCD_CMD_SREN 4'h8
`define SCD_CMD_SREX 4'h9
`define SCD_CMD_PDEN 4'ha
`define SCD_CMD_PDEX 4'hb
`define SCD_CMD_ZQL 4'hc
`define SCD_CMD_ZQS 4'hd
// Address bit positions
`define SCD_AP_BIT 10
`define SCD_BC_BIT 12
// Burst lengths in beats, and core clocks per access
`define SCD_BEATS_FULL 4'h8
`define SCD_BEATS_CHOP 4'h4
`define SCD_CORE_CLOCKS 3'h4
`endif

// file: design/scd_burst.v
// Burst engine: walks the column order of one read or write burst.
// Ignores start pulses while busy; assumes a sampled link clock edge strobe.
`include "scd_consts.vh"
module scd_burst #(
    parameter COL_W = 10
) (
    input wire core_clk_in,
    input wire rst_n_in,
    input wire start_in,
    input wire [COL_W-1:0] col_in,
    input wire chop_in,
    input wire interleave_in,
    input wire half_edge_in,
    output reg busy_out,
    output reg beat_out,
    output reg [COL_W-1:0] col_out,
    output reg last_out
);
    reg [3:0] beat_cnt;
    reg [3:0] beats;
    reg [COL_W-1:0] base;
    reg ilv;
    wire [2:0] idx;
    wire [2:0] ord;
    assign idx = beat_cnt[2:0];
    // Sequential order wraps within the aligned group, interleave XORs
    assign ord = ilv ? (base[2:0] ^ idx) :
        (beats == `SCD_BEATS_CHOP ? {base[2], base[1:0] + idx[1:0]} : base[2:0] + idx);

    ////////////////////////////////////////////////////////////////
    // One beat per link clock half; bursts end after beats count
    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            busy_out <= 1'b0;
            beat_out <= 1'b0;
            col_out <= {COL_W{1'b0}};
            last_out <= 1'b0;
            beat_cnt <= 4'h0;
            beats <= 4'h0;
            base <= {COL_W{1'b0}};
            ilv <= 1'b0;
        end else begin
            beat_out <= 1'b0;
            last_out <= 1'b0;
            if (start_in && !busy_out) begin
                busy_out <= 1'b1;
                beat_cnt <= 4'h0;
                beats <= chop_in ? `SCD_BEATS_CHOP : `SCD_BEATS_FULL;
                base <= col_in;
                ilv <= interleave_in;
            end else if (busy_out && half_edge_in) begin
                beat_out <= 1'b1;
                col_out <= {base[COL_W-1:3], ord};
                beat_cnt <= beat_cnt + 4'h1;
                if (beat_cnt + 4'h1 == beats) begin
                    busy_out <= 1'b0;
                    last_out <= 1'b1;
                end
            end
        end
    end
endmodule

// file: design/scd_decoder.v
// Command decoder and burst front end of an eight-bank DDR memory.
// Assumes all pins come from the controller's clock domain; all but the burst straps sampled twice.
`include "scd_consts.vh"
module scd_decoder #(
    parameter ADDR_W = 14,
    parameter BANKS = 8,
    parameter DQ_W = 16
) (
    input wire core_clk_in,
    input wire rst_n_in,
    input wire link_clk_in,
    input wire cke_in,
    input wire cs_n_in,
    input wire ras_n_in,
    input wire cas_n_in,
    input wire we_n_in,
    input wire [2:0] bank_select_in,
    input wire [ADDR_W-1:0] addr_in,
    input wire [DQ_W-1:0] dq_in,
    input wire lower_byte_mask_in,
    input wire upper_byte_mask_in,
    input wire otf_enable_in,
    input wire fixed_chop_in,
    input wire interleave_in,
    output reg [3:0] cmd_out,
    output reg [2:0] cmd_bank_out,
    output reg [ADDR_W-1:0] row_out,
    output reg [ADDR_W-1:0] mode_opcode_out,
    output reg [BANKS-1:0] bank_open_out,
    output reg power_down_out,
    output reg self_refresh_out,
    output reg wr_beat_out,
    output reg rd_beat_out,
    output reg [9:0] beat_col_out,
    output reg [DQ_W-1:0] wr_data_out,
    output reg [1:0] wr_byte_en_out,
    output reg [8*DQ_W-1:0] core_word_out,
    output reg core_word_valid_out
);
    localparam COL_W = 10;
    localparam ST_IDLE = 2'h0;
    localparam ST_PD = 2'h1;
    localparam ST_SR = 2'h2;
    // Latency: a pin edge reaches the decode two core cycles later, and the
    // command report follows one cycle after the synchronised link rise.
    // Each link half period must span at least two core clocks, or beats
    // and commands are lost; there is no check for a link that runs faster.

    ////////////////////////////////////////////////////////////////
    // Two-flop synchronisers for every pin but the burst straps; first stage read by second only
    // A wide vector may be caught mid-change; it is only used at link edges,
    // when the controller has held every pin steady for half a period
    localparam PIN_W = 8 + ADDR_W + DQ_W;
    wire [PIN_W-1:0] pins_raw;
    reg [PIN_W-1:0] pins_s1;
    reg [PIN_W-1:0] pins_s2;
    assign pins_raw = {link_clk_in, cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in,
        lower_byte_mask_in, upper_byte_mask_in, addr_in, dq_in};
    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            pins_s1 <= {PIN_W{1'b0}};
            pins_s2 <= {PIN_W{1'b0}};
        end else begin
            pins_s1 <= pins_raw;
            pins_s2 <= pins_s1;
        end
    end
    // Bank lines synchronised alongside
    // They feed only the bank map, the burst bank and the reported command bank, read at a link rise
    reg [2:0] bank_s1;
    reg [2:0] bank_s2;
    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            bank_s1 <= 3'h0;
            bank_s2 <= 3'h0;
        end else begin
            bank_s1 <= bank_select_in;
            bank_s2 <= bank_s1;
        end
    end

    wire lclk;
    wire cke;
    wire cs_n;
    wire [2:0] code;
    wire lmask;
    wire umask;
    wire [ADDR_W-1:0] addr;
    wire [DQ_W-1:0] dq;
    assign dq = pins_s2[DQ_W-1:0];
    assign addr = pins_s2[DQ_W+ADDR_W-1:DQ_W];
    assign umask = pins_s2[DQ_W+ADDR_W];
    assign lmask = pins_s2[DQ_W+ADDR_W+1];
    assign code = pins_s2[DQ_W+ADDR_W+4:DQ_W+ADDR_W+2];
    assign cs_n = pins_s2[DQ_W+ADDR_W+5];
    assign cke = pins_s2[DQ_W+ADDR_W+6];
    assign lclk = pins_s2[DQ_W+ADDR_W+7];

    ////////////////////////////////////////////////////////////////
    // Link clock edge finder; commands sampled on the rising edge
    // Both link edges mark a beat; the enable pair moves on rises only,
    // so a low-low pair means a held power state and decodes nothing
    reg lclk_d;
    reg cke_prev;
    wire rise;
    wire half_edge;
    assign rise = lclk && !lclk_d;
    assign half_edge = lclk ^ lclk_d;
    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            lclk_d <= 1'b0;
            cke_prev <= 1'b0;
        end else begin
            lclk_d <= lclk;
            if (rise)
                cke_prev <= cke;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Command decode from cs, strobes and the clock enable pair
    // Bank state is checked only for self refresh entry: access to a closed bank is the
    // controller's fault and is still reported, trading safety for area
    reg [1:0] pstate;
    reg [1:0] next_pstate;
    reg [3:0] next_cmd;
    wire sel;
    wire ap;
    wire all_idle;
    assign sel = !cs_n;
    assign ap = addr[`SCD_AP_BIT];
    assign all_idle = (bank_open_out == {BANKS{1'b0}});
    always @* begin
        next_cmd = `SCD_CMD_NONE;
        next_pstate = pstate;
        if (cke_prev && cke && pstate == ST_IDLE) begin
            if (sel) begin
                case (code)
                    `SCD_CODE_ACT: next_cmd = `SCD_CMD_ACT;
                    `SCD_CODE_PRE: next_cmd = ap ? `SCD_CMD_PREA : `SCD_CMD_PRE;
                    `SCD_CODE_WR: next_cmd = `SCD_CMD_WR;
                    `SCD_CODE_RD: next_cmd = `SCD_CMD_RD;
                    `SCD_CODE_MRW: next_cmd = `SCD_CMD_MRW;
                    `SCD_CODE_REF: next_cmd = `SCD_CMD_REF;
                    `SCD_CODE_ZQ: next_cmd = ap ? `SCD_CMD_ZQL : `SCD_CMD_ZQS;
                    default: next_cmd = `SCD_CMD_NONE;
                endcase
            end
        end else if (cke_prev && !cke && pstate == ST_IDLE) begin
            // Self refresh needs every bank closed, else nothing decodes; power-down needs a deselect or no-operation
            if (sel && code == `SCD_CODE_REF && all_idle) begin
                next_cmd = `SCD_CMD_SREN;
                next_pstate = ST_SR;
            end else if (!sel || code == `SCD_CODE_NOP) begin
                next_cmd = `SCD_CMD_PDEN;
                next_pstate = ST_PD;
            end
        end else if (!cke_prev && cke && pstate != ST_IDLE) begin
            // Either low-power state is left here on a deselect or no-operation; a real command is dropped and the state held
            if (!sel || code == `SCD_CODE_NOP) begin
                next_cmd = pstate == ST_SR ? `SCD_CMD_SREX : `SCD_CMD_PDEX;
                next_pstate = ST_IDLE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Burst engine drives column order and beat timing
    // Only one burst at a time: a read or write that lands while one runs
    // is reported on the command output but not carried out, and it must
    // not disturb the kind, bank or precharge of the burst in flight
    wire b_busy;
    wire b_beat;
    wire [COL_W-1:0] b_col;
    wire b_last;
    wire start;
    wire chop;
    reg is_write;
    reg ap_pending;
    reg [2:0] burst_bank;
    assign start = rise && (next_cmd == `SCD_CMD_WR || next_cmd == `SCD_CMD_RD);
    // Chop bit low means four beats when on-the-fly is on
    // Burst straps are read directly: change them only between bursts
    assign chop = otf_enable_in ? !addr[`SCD_BC_BIT] : fixed_chop_in;
    scd_burst #(.COL_W(COL_W)) u_burst (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .start_in(start),
        .col_in(addr[COL_W-1:0]),
        .chop_in(chop),
        .interleave_in(interleave_in),
        .half_edge_in(half_edge),
        .busy_out(b_busy),
        .beat_out(b_beat),
        .col_out(b_col),
        .last_out(b_last)
    );

    ////////////////////////////////////////////////////////////////
    // Registered command report, bank state and power state
    // Auto precharge is applied ahead of the decode so that a command in
    // the same cycle, such as an activate, wins over the close
    // Power state moves only at a link rise, together with the report
    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            cmd_out <= `SCD_CMD_NONE;
            cmd_bank_out <= 3'h0;
            row_out <= {ADDR_W{1'b0}};
            mode_opcode_out <= {ADDR_W{1'b0}};
            bank_open_out <= {BANKS{1'b0}};
            pstate <= ST_IDLE;
            power_down_out <= 1'b0;
            self_refresh_out <= 1'b0;
            is_write <= 1'b0;
            ap_pending <= 1'b0;
            burst_bank <= 3'h0;
        end else begin
            // Finished burst closes its bank when auto precharge was asked
            if (b_last && ap_pending) begin
                bank_open_out[burst_bank] <= 1'b0;
                ap_pending <= 1'b0;
            end
            cmd_out <= rise ? next_cmd : `SCD_CMD_NONE;
            if (rise) begin
                pstate <= next_pstate;
                power_down_out <= next_pstate == ST_PD;
                self_refresh_out <= next_pstate == ST_SR;
                cmd_bank_out <= bank_s2;
                case (next_cmd)
                    `SCD_CMD_ACT: begin
                        bank_open_out[bank_s2] <= 1'b1;
                        row_out <= addr;
                    end
                    `SCD_CMD_PRE: bank_open_out[bank_s2] <= 1'b0;
                    `SCD_CMD_PREA: bank_open_out <= {BANKS{1'b0}};
                    `SCD_CMD_MRW: mode_opcode_out <= addr;
                    `SCD_CMD_WR, `SCD_CMD_RD: begin
                        // Taken only when the burst engine accepts it
                        if (!b_busy) begin
                            is_write <= next_cmd == `SCD_CMD_WR;
                            ap_pending <= ap;
                            burst_bank <= bank_s2;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Beat data path with byte masks, gathered into one 8n core word
    // Slot count restarts on the last beat, so a chopped burst fills 0-3
    // Byte enables are reported per beat; the core side applies them on
    // store, so masked bytes still appear in the gathered word
    reg [2:0] slot;
    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            wr_beat_out <= 1'b0;
            rd_beat_out <= 1'b0;
            beat_col_out <= {COL_W{1'b0}};
            wr_data_out <= {DQ_W{1'b0}};
            wr_byte_en_out <= 2'h0;
            core_word_out <= {8*DQ_W{1'b0}};
            core_word_valid_out <= 1'b0;
            slot <= 3'h0;
        end else begin
            wr_beat_out <= b_beat && is_write;
            rd_beat_out <= b_beat && !is_write;
            core_word_valid_out <= b_last;
            if (b_beat) begin
                beat_col_out <= b_col;
                wr_data_out <= dq;
                wr_byte_en_out <= {!umask, !lmask};
                slot <= slot + 3'h1;
                core_word_out[slot*DQ_W +: DQ_W] <= dq;
            end
            if (b_last)
                slot <= 3'h0;
        end
    end
endmodule

// file: dv/scd_asserts.sv
// Checker: each reported command other than refresh and self refresh exit against the pins that caused it.
// Assumes pins stay put four core cycles either side of a link rise.
`include "scd_consts.vh"
module scd_asserts #(
    parameter ADDR_W = 14,
    parameter BANKS = 8
) (
    input wire core_clk_in,
    input wire rst_n_in,
    input wire cke_in,
    input wire cs_n_in,
    input wire ras_n_in,
    input wire cas_n_in,
    input wire we_n_in,
    input wire [ADDR_W-1:0] addr_in,
    input wire [3:0] cmd_out,
    input wire [2:0] cmd_bank_out,
    input wire [ADDR_W-1:0] row_out,
    input wire [ADDR_W-1:0] mode_opcode_out,
    input wire [BANKS-1:0] bank_open_out,
    input wire power_down_out
);
    // Four cycles back lands on the carrying link rise, twelve on the one before
    wire [3:0] pins = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    ////////////////////////////////////////////////////////////////////////////
    property p_wr;
        cmd_out == `SCD_CMD_WR |-> $past(pins, 4) == 4'h4 && $past(cke_in, 12) && $past(cke_in, 4);
    endproperty
    a_wr: assert property (p_wr) else $error("write from wrong pins");
    property p_rd;
        cmd_out == `SCD_CMD_RD |-> $past(pins, 4) == 4'h5 && $past(cke_in, 12) && $past(cke_in, 4);
    endproperty
    a_rd: assert property (p_rd) else $error("read from wrong pins");
    property p_pre;
        (cmd_out == `SCD_CMD_PRE || cmd_out == `SCD_CMD_PREA) |-> $past(pins, 4) == 4'h2
            && $past(addr_in[`SCD_AP_BIT], 4) == (cmd_out == `SCD_CMD_PREA);
    endproperty
    a_pre: assert property (p_pre) else $error("precharge scope wrong");
    property p_mrw;
        cmd_out == `SCD_CMD_MRW |=> $past(pins, 5) == 4'h0 && mode_opcode_out == $past(addr_in, 5);
    endproperty
    a_mrw: assert property (p_mrw) else $error("mode write wrong");
    property p_zq;
        (cmd_out == `SCD_CMD_ZQL || cmd_out == `SCD_CMD_ZQS) |-> $past(pins, 4) == 4'h6
            && $past(addr_in[`SCD_AP_BIT], 4) == (cmd_out == `SCD_CMD_ZQL);
    endproperty
    a_zq: assert property (p_zq) else $error("calibration kind wrong");
    property p_act;
        cmd_out == `SCD_CMD_ACT |=> bank_open_out[cmd_bank_out] && row_out == $past(addr_in, 5);
    endproperty
    a_act: assert property (p_act) else $error("activate not applied");
    property p_pd;
        cmd_out == `SCD_CMD_PDEN |-> $past(cke_in, 12) && !$past(cke_in, 4) ##1 power_down_out;
    endproperty
    a_pd: assert property (p_pd) else $error("power-down entry wrong");
    property p_pdx;
        cmd_out == `SCD_CMD_PDEX |-> !$past(cke_in, 12) && $past(cke_in, 4) ##1 !power_down_out;
    endproperty
    a_pdx: assert property (p_pdx) else $error("power-down exit wrong");
    property p_sren;
        cmd_out == `SCD_CMD_SREN |-> $past(pins, 4) == 4'h1 && !$past(cke_in, 4) && bank_open_out == 0;
    endproperty
    a_sren: assert property (p_sren) else $error("self refresh entry wrong");
endmodule

// file: dv/scd_ctrl_model.sv
// Controller model: free-running link clock, command pins and data lines.
// Assumes the bench calls issue for each command in legal order.
module scd_ctrl_model (
    output logic link_clk_out,
    output logic cke_out,
    output logic cs_n_out,
    output logic ras_n_out,
    output logic cas_n_out,
    output logic we_n_out,
    output logic [2:0] bank_select_out,
    output logic [13:0] addr_out,
    output logic [15:0] dq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Odd start offset keeps the link edges 7ns clear of the core clock edges
    initial begin
        link_clk_out = 1'b0;
        cke_out = 1'b1;
        {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'h7;
        bank_select_out = 3'h0;
        addr_out = 14'h0000;
        dq_out = 16'h0000;
        #7;
        forever #160 link_clk_out = ~link_clk_out;
    end
    // Data moves mid half-period, clear of both sampling edges
    always @(link_clk_out) dq_out <= #80 dq_out + 16'h0001;
    ////////////////////////////////////////////////////////////////////////////
    // Command on one rise, then no-operation with address lines scrambled
    task automatic issue(input logic [3:0] pins, input logic [2:0] bank,
                         input logic [13:0] addr, input logic cke);
        @(negedge link_clk_out);
        {cs_n_out, ras_n_out, cas_n_out, we_n_out} = pins;
        bank_select_out = bank;
        addr_out = addr;
        cke_out = cke;
        @(negedge link_clk_out);
        {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'h7;
        bank_select_out = ~bank;
        addr_out = ~addr;
    endtask
endmodule

// file: dv/tb_top.sv
// Bench: command table through the controller model, then write bursts.
// Assumes the decoder, the controller model and the checker are compiled first.
`include "scd_consts.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, otf, fix, lmask, umask, ilv;
    logic [3:0] seen;
    logic [127:0] last_word;
    logic [9:0] cols [8];
    logic [15:0] dats [8];
    logic [25:0] rows [16];
    int errors, num_checks, nbeats, nbad, nvalid, r;
    wire link_clk, cke, cs_n, ras_n, cas_n, we_n, pd, sr, wr_beat, rd_beat, word_valid;
    wire [9:0] beat_col;
    wire [15:0] wr_data;
    wire [2:0] bank;
    wire [13:0] addr;
    wire [15:0] dq;
    wire [3:0] cmd;
    wire [7:0] bank_open;
    wire [1:0] byte_en;
    wire [127:0] word;
    scd_ctrl_model u_ctrl (.link_clk_out(link_clk), .cke_out(cke), .cs_n_out(cs_n),
        .ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n), .bank_select_out(bank),
        .addr_out(addr), .dq_out(dq));
    scd_decoder dut (.core_clk_in(clk), .rst_n_in(rst_n), .link_clk_in(link_clk),
        .cke_in(cke), .cs_n_in(cs_n), .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n),
        .bank_select_in(bank), .addr_in(addr), .dq_in(dq), .lower_byte_mask_in(lmask),
        .upper_byte_mask_in(umask), .otf_enable_in(otf), .fixed_chop_in(fix),
        .interleave_in(ilv), .cmd_out(cmd), .cmd_bank_out(), .row_out(),
        .mode_opcode_out(), .bank_open_out(bank_open), .power_down_out(pd),
        .self_refresh_out(sr), .wr_beat_out(wr_beat), .rd_beat_out(rd_beat),
        .beat_col_out(beat_col), .wr_data_out(wr_data), .wr_byte_en_out(byte_en),
        .core_word_out(word), .core_word_valid_out(word_valid));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Sampled at the falling edge, once registered outputs have settled
    always @(negedge clk) begin
        if (cmd !== 4'h0) seen <= cmd;
        if (wr_beat === 1'b1 || rd_beat === 1'b1) begin
            nbeats <= nbeats + 1;
            cols[nbeats % 8] <= beat_col;
            dats[nbeats % 8] <= wr_data;
        end
        if (wr_beat === 1'b1 && byte_en !== ~{umask, lmask}) nbad <= nbad + 1;
        if (word_valid === 1'b1) begin
            last_word <= word;
            nvalid <= nvalid + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Activate then write; masks stay fixed so every beat's enables can be judged
    task automatic burst(input logic [1:0] mask, input logic [4:0] mode, input int n);
        int v0, e;
        @(negedge clk);
        {umask, lmask} = mask;
        {otf, fix} = mode[1:0];
        ilv = mode[4];
        u_ctrl.issue({1'b0, `SCD_CODE_ACT}, 3'h2, 14'h0077, 1'b1);
        nbeats = 0;
        nbad = 0;
        v0 = nvalid;
        u_ctrl.issue({1'b0, `SCD_CODE_WR}, 3'h2, {1'b0, mode[2], 1'b0, mode[3], 10'h005}, 1'b1);
        for (int k = 0; k < 200 && nvalid == v0; k++) @(negedge clk);
        if (nvalid == v0) begin
            errors++;
            conclude();
        end
        repeat (4) @(negedge clk);
        check(nbeats, n);
        check(nbad, 0);
        check(bank_open[2], !mode[3]);
        for (int k = 1; k < n; k++) check(last_word[16*k+:16], 16'(last_word[15:0] + k));
        // Column 5 starts mid-group, so wrap and interleave orders all differ
        for (int k = 0; k < n; k++) begin
            e = mode[4] ? 5 ^ k : (n == 4 ? 4 + (1 + k) % 4 : (5 + k) % 8);
            check(cols[k], e);
            check(dats[k], last_word[16*k+:16]);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        otf = 1'b1;
        fix = 1'b0;
        lmask = 1'b0;
        umask = 1'b0;
        ilv = 1'b0;
        seen = 4'h0;
        rows = '{
            {`SCD_CMD_ACT, 2'h2, `SCD_CODE_ACT, 3'h3, 14'h0123},
            {`SCD_CMD_ACT, 2'h2, `SCD_CODE_ACT, 3'h5, 14'h0456},
            {`SCD_CMD_NONE, 2'h3, `SCD_CODE_ACT, 3'h6, 14'h0001},
            {`SCD_CMD_WR, 2'h2, `SCD_CODE_WR, 3'h3, 14'h1010},
            {`SCD_CMD_RD, 2'h2, `SCD_CODE_RD, 3'h3, 14'h0020},
            {`SCD_CMD_PRE, 2'h2, `SCD_CODE_PRE, 3'h5, 14'h0000},
            {`SCD_CMD_PREA, 2'h2, `SCD_CODE_PRE, 3'h0, 14'h0400},
            {`SCD_CMD_REF, 2'h2, `SCD_CODE_REF, 3'h0, 14'h0000},
            {`SCD_CMD_MRW, 2'h2, `SCD_CODE_MRW, 3'h1, 14'h0abc},
            {`SCD_CMD_ZQL, 2'h2, `SCD_CODE_ZQ, 3'h0, 14'h0400},
            {`SCD_CMD_ZQS, 2'h2, `SCD_CODE_ZQ, 3'h0, 14'h0000},
            {`SCD_CMD_PDEN, 2'h0, `SCD_CODE_NOP, 3'h0, 14'h0000},
            {`SCD_CMD_NONE, 2'h0, `SCD_CODE_ACT, 3'h2, 14'h0000},
            {`SCD_CMD_PDEX, 2'h2, `SCD_CODE_NOP, 3'h0, 14'h0000},
            {`SCD_CMD_SREN, 2'h0, `SCD_CODE_REF, 3'h0, 14'h0000},
            {`SCD_CMD_SREX, 2'h2, `SCD_CODE_NOP, 3'h0, 14'h0000}};
        repeat (8) @(negedge clk);
        check(cmd, 4'h0);
        check(bank_open, 8'h00);
        rst_n = 1'b1;
        // Enable pair starts low: one link rise must pass before any command
        repeat (16) @(negedge clk);
        // Banks are opened before access and closed before mode writes
        for (r = 0; r < 16; r++) begin
            seen = 4'h0;
            u_ctrl.issue(rows[r][20:17], rows[r][16:14], rows[r][13:0], rows[r][21]);
            repeat (40) @(negedge clk);
            check(seen, rows[r][25:22]);
            check(pd, r == 11 || r == 12);
            check(sr, r == 14);
        end
        burst(2'b01, 5'b01110, 8);
        burst(2'b10, 5'b11010, 4);
        burst(2'b00, 5'b11000, 8);
        burst(2'b00, 5'b00001, 4);
        // Reset in mid-run drops the bank that the last burst left open
        @(negedge clk);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        check(bank_open, 8'h00);
        check(word_valid, 1'b0);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        check(cmd, 4'h0);
        conclude();
    end
endmodule
bind scd_decoder scd_asserts #(.ADDR_W(ADDR_W), .BANKS(BANKS)) u_chk (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .cke_in(cke_in), .cs_n_in(cs_n_in),
    .ras_n_in(ras_n_in), .cas_n_in(cas_n_in), .we_n_in(we_n_in), .addr_in(addr_in),
    .cmd_out(cmd_out), .cmd_bank_out(cmd_bank_out), .row_out(row_out),
    .mode_opcode_out(mode_opcode_out), .bank_open_out(bank_open_out),
    .power_down_out(power_down_out));
